// file: common/adc_ctl_pkg.sv
// Types shared by the converter control block
package adc_ctl_pkg;
  // Host control pins after synchronising
  typedef struct packed {
    logic sel_n;  // Chip select, low active
    logic rd_cv;  // Read or convert line
    logic upper;  // Upper half select
  } ctl_pins_t;
  // Approximation sequencer, Gray along the path
  typedef enum logic [1:0] {
    SAR_IDLE  = 2'h0,
    SAR_CONV  = 2'h1,
    SAR_STORE = 2'h3,
    SAR_LOAD  = 2'h2
  } sar_state_t;
endpackage

// file: common/adc_ctl_regs.svh
// Constants of the converter control block
`ifndef ADC_CTL_REGS_SVH
`define ADC_CTL_REGS_SVH
`define RESULT_W      12
`define NIB_W         4
`define CLK_PERIOD_NS 100
`define CONV_TYP_NS   2470
`define CONV_MAX_NS   2700
`define ACQ_MAX_NS    300
`define PULSE_MIN_NS  40
`define CONV_MAX_CYC  (`CONV_MAX_NS / `CLK_PERIOD_NS)
`define ACQ_MAX_CYC   (`ACQ_MAX_NS / `CLK_PERIOD_NS)
`define BIT_CYC       (`CONV_TYP_NS / (`CLK_PERIOD_NS * `RESULT_W))
`define BIT_CNT_W     4
`define BUF_DEPTH     2
`endif

// file: dv/host_model.sv
// Host model that drives the converter control pins
`timescale 1ns/100ps
module host_model (
  input  wire logic clock_i,
  output logic      select_n_o,
  output logic      read_convert_o,
  output logic      upper_half_select_o
);
  // Idle: deselected, line high, lower half
  initial begin
    select_n_o          = 1'b1;
    read_convert_o      = 1'b1;
    upper_half_select_o = 1'b0;
  end
  // Pins change just after an edge; callers hold low pulses >= 3 cycles
  task automatic set(input logic s, input logic r, input logic u);
    @(posedge clock_i);
    select_n_o          <= s;
    read_convert_o      <= r;
    upper_half_select_o <= u;
  endtask
  // Hold pins, return at a falling edge where outputs are settled
  task automatic idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module testbench;
  logic        clock_i = 1'b0;  // System clock
  logic        rst_b_i = 1'b0;  // Reset, low active
  logic [11:0] analog;          // Front-end code
  logic        en;              // Clock enable
  logic        sel_n;           // Host pins
  logic        rd_cv;
  logic        upper;
  logic        busy_n;          // Design outputs
  logic        hold;
  logic [11:0] data;
  logic [11:0] data_oe;
  logic [11:0] note[$];         // Expected words, oldest first
  logic [11:0] last;            // Latest result
  logic        oe_q = 1'b0;     // Enables seen last cycle
  int          n_fail = 0;
  int          compares = 0;
  int          cyc = 0;
  int          bc = 0;          // Busy-low cycle count

  // 10 MHz clock
  always #50 clock_i = ~clock_i;

  host_model host (.clock_i(clock_i), .select_n_o(sel_n), .read_convert_o(rd_cv),
    .upper_half_select_o(upper));

  adc_convert_read_control uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .enable_i(en),
    .select_n_i(sel_n), .read_convert_i(rd_cv), .upper_half_select_i(upper),
    .analog_code_i(analog), .busy_n_o(busy_n), .hold_o(hold), .data_o(data),
    .data_oe_o(data_oe));

  // Compare and count
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Counts, verdict, end of run
  task automatic stop_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watcher: drivers off while busy, busy length, word on enable
  always @(negedge clock_i) begin
    if (busy_n === 1'b0) check(data_oe, 12'h000);
    if (busy_n === 1'b0) begin
      if (en === 1'b1) bc++;
    end else if (bc > 0) begin
      check(12'(bc >= 24 && bc <= 27), 12'h001);
      check({11'h0, hold}, 12'h000);
      check(data, last);
      bc = 0;
    end
    if (data_oe === 12'hFFF && !oe_q) check(data, note.size() ? note.pop_front() : 'x);
    oe_q = (data_oe === 12'hFFF);
  end

  // Hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test;
    end
  end

  // Bounded wait for a busy level
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy_n !== lvl && n < 40) begin
      @(negedge clock_i);
      n++;
    end
    check(12'(n < 40), 12'h001);
  endtask

  // One conversion; low keeps the line resting low, poke pulses during busy
  task automatic conv(input logic [11:0] code, input logic low, input logic poke);
    note.push_back(code);
    last = code;
    @(posedge clock_i);
    analog <= code;
    host.set(1'b0, 1'b0, 1'b0);
    host.idle(3);
    if (!low) host.set(1'b0, 1'b1, 1'b0);
    wait_busy(1'b0);
    check({11'h0, hold}, 12'h001);
    @(posedge clock_i);
    analog <= ~code;
    if (poke) begin
      host.set(1'b0, 1'b0, 1'b1);
      host.idle(3);
      host.set(1'b0, 1'b1, 1'b0);
      en <= 1'b0; // Freeze four edges mid-conversion
      repeat (4) @(posedge clock_i);
      en <= 1'b1;
    end
    wait_busy(1'b1);
    if (low) begin
      host.idle(6);
      check(data_oe, 12'h000);
      host.set(1'b0, 1'b1, 1'b0);
    end
    host.idle(8);
    check({11'h0, busy_n}, 12'h001);
  endtask

  // Falling line with select or upper half high must not start
  task automatic refuse(input logic s, input logic u);
    host.set(1'b1, 1'b1, u);
    host.idle(4);
    check(data_oe, 12'h000);
    host.set(s, 1'b0, u);
    host.idle(3);
    if (!s) note.push_back({last[11:8], 4'h0, last[11:8]});
    host.set(s, 1'b1, u);
    host.idle(8);
    check({11'h0, busy_n}, 12'h001);
    host.set(1'b1, 1'b1, 1'b0);
    host.idle(4);
    note.push_back(last);
    host.set(1'b0, 1'b1, 1'b0);
    host.idle(8);
    check({11'h0, busy_n}, 12'h001);
  endtask

  // Main sequence
  initial begin
    void'($urandom(44333));
    en <= 1'b1;
    analog <= 12'($urandom);
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    host.idle(3);
    check({10'h0, busy_n, hold}, 12'h002);
    note.push_back(12'h000);
    host.set(1'b0, 1'b1, 1'b0);
    host.idle(6);
    conv(12'h000, 1'b0, 1'b0);
    conv(12'hFFF, 1'b0, 1'b1);
    refuse(1'b0, 1'b1);
    refuse(1'b1, 1'b0);
    conv(12'hA5C, 1'b1, 1'b0);
    conv(12'h3C7, 1'b0, 1'b1);
    repeat (6) conv(12'($urandom), 1'($urandom), 1'b0);
    refuse(1'b0, 1'b1);
    stop_test;
  end
endmodule

// file: logic/adc_convert_read_control.sv
// Convert, busy and read-out control of a 12-bit sampling converter
`timescale 1ns/100ps
`include "adc_ctl_regs.svh"
// Notes on behaviour
// - Qualified falling edge holds sample, starts conversion
// - Only falling read_convert edge starts conversion
// - Upper half select high blocks start
// - Select high or busy low refuses start
// - Busy low until result sits in latches
// - Inputs ignored while busy is low
// - Conversion finishes within 2.7 microseconds
// - Acquisition within 300 ns, 3 us spacing
// - Tracking resumes before busy rises
// - Drivers on only when read, idle, selected
// - Select high forces all data line drivers off
// - Upper half maps top nibble low lines
// - Convert mode: off at fall, on after
// - Read mode: old result while line high
module adc_convert_read_control
  import adc_ctl_pkg::*;
#(
  parameter int RESULT_W = `RESULT_W,
  parameter int BIT_CYC  = `BIT_CYC
) (
  input  wire logic                clock_i,
  input  wire logic                rst_b_i,
  input  wire logic                enable_i,
  input  wire logic                select_n_i,
  input  wire logic                read_convert_i,
  input  wire logic                upper_half_select_i,
  input  wire logic [RESULT_W-1:0] analog_code_i,
  output logic                     busy_n_o,
  output logic                     hold_o,
  output logic      [RESULT_W-1:0] data_o,
  output logic      [RESULT_W-1:0] data_oe_o
);

  // Output word for the chosen half
  function automatic logic [RESULT_W-1:0] map_out(
    input logic [RESULT_W-1:0] r,
    input logic                upper
  );
    logic [RESULT_W-1:0] w;
    w = r;
    if (upper) begin
      w = '0;
      w[RESULT_W-1 -: `NIB_W] = r[RESULT_W-1 -: `NIB_W];
      w[`NIB_W-1:0]           = r[RESULT_W-1 -: `NIB_W];
    end
    return w;
  endfunction

  // Pin synchroniser stages
  ctl_pins_t pins_meta;   // First stage, read only by second
  ctl_pins_t pins;        // Second stage, safe to use
  logic      rd_cv_last;  // Previous read line level

  // Sequencer and result path
  sar_state_t              state;       // Approximation state
  logic [RESULT_W-1:0]     held;        // Frozen sample
  logic [RESULT_W-1:0]     trial;       // Code being built
  logic [`BIT_CNT_W-1:0]   bit_idx;     // Bit under trial
  logic [`BIT_CNT_W-1:0]   cyc_cnt;     // Cycles within a bit
  logic                    start;       // Accepted convert command
  logic                    drive;       // Read window open
  logic                    next_oe;     // Drivers for next cycle

  // Two-entry buffer between sequencer and latches
  logic [RESULT_W-1:0]     buf_mem [`BUF_DEPTH];  // Entries
  logic                    buf_wr;      // Write pointer
  logic                    buf_rd;      // Read pointer
  logic [1:0]              buf_cnt;     // Words held
  logic                    in_valid;    // Sequencer offers word
  logic                    in_ready;    // Buffer has room
  logic                    out_valid;   // Buffer has a word
  logic                    out_ready;   // Latches may take it
  logic [RESULT_W-1:0]     latch;       // Output latches

  // Two flops on every host pin
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_meta  <= '{sel_n: 1'b1, rd_cv: 1'b1, upper: 1'b0};
      pins       <= '{sel_n: 1'b1, rd_cv: 1'b1, upper: 1'b0};
      rd_cv_last <= 1'b1;
    end else if (enable_i) begin
      pins_meta  <= '{sel_n: select_n_i, rd_cv: read_convert_i,
                      upper: upper_half_select_i};
      pins       <= pins_meta;
      rd_cv_last <= pins.rd_cv;
    end
  end

  // Start qualification
  always_comb begin
    // Only a high to low step counts
    start = rd_cv_last && !pins.rd_cv;
    // Upper half select must be low
    start = start && !pins.upper;
    // Selected and idle, else refused
    start = start && !pins.sel_n && busy_n_o && (state == SAR_IDLE);
    // Pulses narrower than a sample are missed
  end

  // Approximation sequencer
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state   <= SAR_IDLE;
      held    <= '0;
      trial   <= '0;
      bit_idx <= '0;
      cyc_cnt <= '0;
    end else if (enable_i) begin
      case (state)
        SAR_IDLE: begin
          // Track until a command freezes the sample
          if (start) begin
            held    <= analog_code_i;
            trial   <= '0;
            trial[RESULT_W-1] <= 1'b1;
            bit_idx <= `BIT_CNT_W'(RESULT_W - 1);
            cyc_cnt <= '0;
            state   <= SAR_CONV;
          end
        end
        SAR_CONV: begin
          // Host pins have no effect here
          if (cyc_cnt == `BIT_CNT_W'(BIT_CYC - 1)) begin
            cyc_cnt <= '0;
            // Keep or drop the trial bit
            if (trial > held) begin
              trial[bit_idx] <= 1'b0;
            end
            if (bit_idx == '0) begin
              state <= SAR_STORE;
            end else begin
              trial[bit_idx - 1'b1] <= 1'b1;
              bit_idx <= bit_idx - 1'b1;
            end
          end else begin
            cyc_cnt <= cyc_cnt + 1'b1;
          end
        end
        SAR_STORE: begin
          // Hand the word on once the buffer has room
          if (in_ready) begin
            state <= SAR_LOAD;
          end
        end
        SAR_LOAD: begin
          // Wait for the latches to hold the word
          if (!out_valid) begin
            state <= SAR_IDLE;
          end
        end
        default: begin
          state <= SAR_IDLE;
        end
      endcase
    end
  end

  // Hold switch: sampling restarts as soon as bits are decided
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_o <= 1'b0;
    end else if (enable_i) begin
      if (start) begin
        hold_o <= 1'b1;
      end else if (state == SAR_STORE) begin
        hold_o <= 1'b0;
      end
    end
  end

  // Buffer handshake terms
  assign in_valid  = (state == SAR_STORE);
  assign in_ready  = (buf_cnt != 2'(`BUF_DEPTH));
  assign out_valid = (buf_cnt != 2'h0);
  // Latches refresh only while nobody reads them
  assign out_ready = !drive;

  // Two-entry buffer storage and pointers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_wr  <= 1'b0;
      buf_rd  <= 1'b0;
      buf_cnt <= 2'h0;
      buf_mem <= '{default: '0};
    end else if (enable_i) begin
      if (in_valid && in_ready) begin
        buf_mem[buf_wr] <= trial;
        buf_wr          <= !buf_wr;
      end
      if (out_valid && out_ready) begin
        buf_rd <= !buf_rd;
      end
      case ({in_valid && in_ready, out_valid && out_ready})
        2'h2:    buf_cnt <= buf_cnt + 2'h1;
        2'h1:    buf_cnt <= buf_cnt - 2'h1;
        default: buf_cnt <= buf_cnt;
      endcase
    end
  end

  // Output latches take the next word
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch <= '0;
    end else if (enable_i) begin
      if (out_valid && out_ready) begin
        latch <= buf_mem[buf_rd];
      end
    end
  end

  // Busy flag
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_n_o <= 1'b1;
    end else if (enable_i) begin
      if (start) begin
        busy_n_o <= 1'b0;
      end else if (state == SAR_LOAD && !out_valid) begin
        busy_n_o <= 1'b1;
      end
    end
  end

  // Read window and driver control
  always_comb begin
    // All three conditions at once
    drive   = pins.rd_cv && busy_n_o && !pins.sel_n;
    // Falling edge or new command shuts drivers
    next_oe = drive && !start;
  end

  // Data pins and their enables
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_o    <= '0;
      data_oe_o <= '0;
    end else if (enable_i) begin
      if (pins.sel_n) begin
        data_oe_o <= '0;
      end else begin
        data_oe_o <= {RESULT_W{next_oe}};
      end
      data_o <= map_out(latch, pins.upper);
    end
  end

  // Checks next to the logic

  // Run length of the busy low phase, frozen with the enable
  logic [`BIT_CNT_W+1:0] busy_run;  // Cycles busy has been low
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_run <= '0;
    end else if (enable_i) begin
      busy_run <= busy_n_o ? '0 : busy_run + 1'b1;
    end
  end

  start_drops_busy_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    start && enable_i |=> !busy_n_o && hold_o)
    else $error("accepted command did not drop busy");

  upper_blocks_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    pins.upper && busy_n_o && enable_i |=> busy_n_o)
    else $error("start taken with upper half select high");

  unselected_refuses_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    pins.sel_n && busy_n_o && enable_i |=> busy_n_o)
    else $error("start taken while not selected");

  busy_bounded_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    busy_run <= (`BIT_CNT_W+2)'(`CONV_MAX_CYC))
    else $error("busy stayed low too long");

  // Frozen sample may not move under a running conversion
  no_restart_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !busy_n_o |=> $stable(held))
    else $error("conversion restarted while busy");

  track_before_busy_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    $rose(busy_n_o) |-> !hold_o && $past(!hold_o))
    else $error("tracking not resumed before busy rose");

  drivers_idle_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (data_oe_o != '0) |-> $past(busy_n_o) && $past(pins.rd_cv))
    else $error("drivers on outside the read window");

  select_off_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    $past(pins.sel_n) && $past(enable_i) |-> data_oe_o == '0)
    else $error("drivers on while deselected");

  upper_map_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    $past(pins.upper) && $past(enable_i) |->
      data_o[`NIB_W-1:0] == $past(latch[RESULT_W-1 -: `NIB_W])
      && data_o[2*`NIB_W-1 -: `NIB_W] == '0)
    else $error("upper half mapping wrong");

  // Busy only falls after a qualified falling read line
  edge_only_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    $fell(busy_n_o) |-> $past(rd_cv_last && !pins.rd_cv && !pins.sel_n && !pins.upper))
    else $error("conversion began without a qualified edge");

  // Result sits in the latches when busy returns high
  latched_result_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    $rose(busy_n_o) |-> latch == held)
    else $error("busy rose before the result was latched");

  // Tracking window before the next command stays short
  acquire_short_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    $fell(hold_o) |-> ##[1:3] busy_n_o)
    else $error("acquisition window too long");

  // Accepted command turns the drivers off
  convert_off_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    start && enable_i |=> data_oe_o == '0)
    else $error("drivers on after a convert command");

  // Falling read line releases the data lines
  read_fall_off_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    $fell(pins.rd_cv) && enable_i |=> data_oe_o == '0)
    else $error("drivers on after read line fell");

endmodule
